//--- core/adcsc_top.sv
// Converter status flags, result holding and channel/reference select
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defs.svh"

module adcsc_top #(
   parameter bit AUX_PRESENT = 1'b1
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESETN,
   // Special function register access
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_RD,
   input wire logic SFR_BIT_WR,
   input wire logic [7:0] SFR_BIT_ADDR,
   input wire logic SFR_BIT_VAL,
   output logic [7:0] SFR_RDATA,
   output logic SFR_RVALID,
   // Mode register write strobe
   input wire logic MODE_WR,
   input wire logic [2:0] MODE_FIELD,
   // Primary converter datapath
   input wire logic P_ACTIVE,
   input wire logic P_DONE,
   input wire logic [23:0] P_RESULT,
   input wire logic P_CAL_DONE,
   input wire logic P_CAL_FAIL,
   output logic P_WR_EN,
   output logic [23:0] P_DATA,
   // Auxiliary converter datapath
   input wire logic A_ACTIVE,
   input wire logic A_DONE,
   input wire logic [23:0] A_RESULT,
   input wire logic A_CAL_DONE,
   input wire logic A_CAL_FAIL,
   input wire logic A_TEMP_SEL,
   output logic A_WR_EN,
   output logic [23:0] A_DATA,
   // Reference pair A detector, asynchronous
   input wire logic REF_A_BAD,
   // Primary multiplexer controls
   output logic [1:0] REF_SEL,
   output logic [3:0] CH_SEL,
   output logic [3:0] POS_IN,
   output logic [3:0] NEG_IN,
   output logic NOREF
);

   adcsc_pkg::adcsc_state_s s_r;
   adcsc_pkg::adcsc_state_s s_nxt;
   logic st_wr;
   logic sel_wr;
   logic p_clr;
   logic a_clr;
   logic mode_cal;
   logic p_open;
   logic a_open;
   logic p_take;
   logic a_take;
   logic p_cal;
   logic a_cal;
   logic [23:0] p_val;
   logic [23:0] a_val;
   logic [7:0] status_rd;
   logic [3:0] pair_base;

   // Reported status byte; unimplemented low bits read zero
   assign status_rd = {s_r.p_ready, s_r.a_ready, s_r.cal, s_r.noref, s_r.p_fault, s_r.a_fault, 2'b00};

   // Decode of software accesses
   assign st_wr = SFR_WR && (SFR_ADDR == `ADCSC_STATUS_ADDR);
   assign sel_wr = SFR_WR && (SFR_ADDR == `ADCSC_SELECT_ADDR);
   // Mode codes four and up start a calibration, so they also drop the result flags
   assign mode_cal = MODE_WR && (MODE_FIELD >= `ADCSC_MODE_CAL_MIN);

   // Result flag clears: zero written by byte or bit, or calibration start
   assign p_clr = (st_wr && !SFR_WDATA[`ADCSC_B_P_READY])
                  || (SFR_BIT_WR && !SFR_BIT_VAL
                      && (SFR_BIT_ADDR == (`ADCSC_STATUS_ADDR | 8'h07)))
                  || mode_cal;
   assign a_clr = (st_wr && !SFR_WDATA[`ADCSC_B_A_READY])
                  || (SFR_BIT_WR && !SFR_BIT_VAL
                      && (SFR_BIT_ADDR == (`ADCSC_STATUS_ADDR | 8'h06)))
                  || mode_cal;

   // A completion in the clearing cycle is accepted, so the event is not lost
   assign p_open = !s_r.p_ready || p_clr;
   assign a_open = AUX_PRESENT && (!s_r.a_ready || a_clr);
   // Completions that the flags let through; the rest are dropped
   assign p_take = P_DONE && p_open;
   assign a_take = A_DONE && a_open;
   assign p_cal = P_CAL_DONE && p_open;
   assign a_cal = A_CAL_DONE && a_open && !A_TEMP_SEL;

   // Write enables toward the datapath's own result registers
   // Combinational, so a clear reopens the path in the very cycle it lands
   assign P_WR_EN = p_open;
   assign A_WR_EN = a_open;

   // Results clamp to all ones while the reference is missing
   assign p_val = s_r.noref ? {`ADCSC_DW{1'b1}} : P_RESULT;
   assign a_val = s_r.noref ? {`ADCSC_DW{1'b1}} : A_RESULT;

   // First input of the selected differential pair
   assign pair_base = 4'((SFR_WDATA[3:0] - `ADCSC_CH_DIFF0) << 1) + 4'h1;

   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = SFR_RD;
      s_nxt.rdata = 8'h00;
      if (SFR_RD) begin
         case (SFR_ADDR)
            `ADCSC_STATUS_ADDR: begin
               s_nxt.rdata = status_rd;
            end
            `ADCSC_SELECT_ADDR: begin
               s_nxt.rdata = s_r.sel;
            end
            default: begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end
      // Result flags: set wins over clear
      s_nxt.p_ready = (s_r.p_ready && !p_clr) || p_take || p_cal;
      s_nxt.a_ready = AUX_PRESENT && ((s_r.a_ready && !a_clr) || a_take || a_cal);
      // Calibration flag is cleared only by a mode write
      s_nxt.cal = (s_r.cal && !MODE_WR) || p_cal || a_cal;
      // Fault flags: saturated stored result or failed calibration
      s_nxt.p_fault = (s_r.p_fault && !MODE_WR)
                   || (p_take && ((&p_val) || (p_val == '0)))
                   || (p_cal && P_CAL_FAIL);
      s_nxt.a_fault = AUX_PRESENT && ((s_r.a_fault && !MODE_WR)
                   || (a_take && ((&a_val) || (a_val == '0)))
                   || (a_cal && A_CAL_FAIL));
      // Held results
      if (p_take) begin
         s_nxt.p_data = p_val;
      end
      if (a_take) begin
         s_nxt.a_data = a_val;
      end
      // Reference pair A detector: three stages, change once stages two and three agree
      s_nxt.ref_sync = {s_r.ref_sync[1:0], REF_A_BAD};
      if (s_r.ref_sync[1] == s_r.ref_sync[2]) begin
         s_nxt.ref_bad = s_r.ref_sync[2];
      end
      // Only pair A is watched, and only while a converter runs
      s_nxt.noref = s_r.ref_bad && (P_ACTIVE || (AUX_PRESENT && A_ACTIVE));
      // Select register; bit 4 stays zero
      if (sel_wr) begin
         s_nxt.sel = SFR_WDATA & `ADCSC_SEL_WMASK;
         if (SFR_WDATA[3:0] < `ADCSC_CH_DIFF0) begin
            s_nxt.pos_in = SFR_WDATA[3:0] + 4'h1;
            s_nxt.neg_in = `ADCSC_IN_COMMON;
         end else if (SFR_WDATA[3:0] == `ADCSC_CH_COMMON) begin
            s_nxt.pos_in = `ADCSC_IN_COMMON;
            s_nxt.neg_in = `ADCSC_IN_COMMON;
         end else begin
            s_nxt.pos_in = pair_base;
            s_nxt.neg_in = pair_base + 4'h1;
         end
      end
   end

   // State register; code 0 decodes to input one against common
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         s_r <= '0;
         s_r.pos_in <= 4'h1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state
   assign SFR_RDATA = s_r.rdata;
   assign SFR_RVALID = s_r.rvalid;
   assign P_DATA = s_r.p_data;
   assign A_DATA = s_r.a_data;
   assign REF_SEL = s_r.sel[7:6];
   assign CH_SEL = s_r.sel[3:0];
   assign POS_IN = s_r.pos_in;
   assign NEG_IN = s_r.neg_in;
   assign NOREF = s_r.noref;

   // Checks next to the logic
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);

   // Primary completion seen with the flag down
   sequence done_seen;
      P_DONE && !s_r.p_ready;
   endsequence
   // Primary flag up one cycle on
   sequence flag_up;
      ##1 s_r.p_ready;
   endsequence
   // Auxiliary completion seen with its flag down
   sequence aux_done_seen;
      AUX_PRESENT && A_DONE && !s_r.a_ready;
   endsequence
   // Auxiliary flag up one cycle on
   sequence aux_flag_up;
      ##1 s_r.a_ready;
   endsequence
   // Primary calibration accepted
   sequence cal_seen;
      P_CAL_DONE && p_open;
   endsequence
   // Calibration and result flags both up one cycle on
   sequence cal_flags_up;
      ##1 (s_r.cal && s_r.p_ready);
   endsequence
   // Reference judged bad while the primary converter runs
   sequence ref_lost_run;
      s_r.ref_bad && P_ACTIVE;
   endsequence
   // Missing reference flag up one cycle on
   sequence noref_up;
      ##1 s_r.noref;
   endsequence

   // Primary result flag follows a completion
   p_ready_set_a: assert property (done_seen |-> flag_up)
      else $error("primary flag not set after done");

   // Primary result flag holds until a clear
   p_ready_hold_a: assert property (s_r.p_ready && !p_clr && !p_take && !p_cal |=> s_r.p_ready)
      else $error("primary flag dropped without clear");

   // Held primary data frozen while the flag stands
   data_block_a: assert property (s_r.p_ready && !p_clr |=> $stable(s_r.p_data))
      else $error("primary data changed while flag set");

   // Temperature sensor calibration never completes
   temp_cal_a: assert property (A_CAL_DONE && A_TEMP_SEL && !P_CAL_DONE && !s_r.cal |=> !s_r.cal)
      else $error("calibration flag set by temperature calibration");

   // Mode write drops calibration and primary fault flags when no new event lands
   cal_clear_a: assert property (MODE_WR && !P_DONE && !P_CAL_DONE && !A_CAL_DONE |=> !s_r.cal && !s_r.p_fault)
      else $error("mode write left flags set");

   // Missing reference only while a converter runs
   noref_idle_a: assert property (!P_ACTIVE && !A_ACTIVE |=> !s_r.noref)
      else $error("missing reference flagged while idle");

   // Primary result clamps to ones without a reference
   clamp_ones_a: assert property (s_r.noref && P_DONE && p_open |=> &s_r.p_data)
      else $error("result not clamped while reference missing");

   // Zero result raises the primary fault flag
   sat_err_a: assert property (P_DONE && p_open && !s_r.noref && (P_RESULT == '0) |=> s_r.p_fault)
      else $error("fault flag missing on saturated result");

   // Select bit four never stores a one
   sel_bit4_a: assert property (sel_wr |=> !s_r.sel[4])
      else $error("unimplemented select bit stored");

   // Differential pair three and four
   diff_pair_a: assert property (sel_wr && SFR_WDATA[3:0] == 4'hB |=> s_r.pos_in == 4'h3 && s_r.neg_in == 4'h4)
      else $error("differential pair decode wrong");

   // Auxiliary result flag follows a completion
   a_ready_set_a: assert property (aux_done_seen |-> aux_flag_up)
      else $error("auxiliary flag not set after done");

   // Auxiliary result flag holds until a clear
   a_ready_hold_a: assert property (s_r.a_ready && !a_clr |=> s_r.a_ready)
      else $error("auxiliary flag dropped without clear");

   // Held auxiliary data frozen while its flag stands
   aux_block_a: assert property (s_r.a_ready && !a_clr |=> $stable(s_r.a_data))
      else $error("auxiliary data changed while flag set");

   // Primary write path closed while its flag stands
   p_wr_closed_a: assert property (s_r.p_ready && !p_clr |-> !P_WR_EN)
      else $error("primary write enable open while flag set");

   // Auxiliary write path closed while its flag stands
   a_wr_closed_a: assert property (s_r.a_ready && !a_clr |-> !A_WR_EN)
      else $error("auxiliary write enable open while flag set");

   // Byte write of zero clears the primary flag
   byte_clear_a: assert property (st_wr && !SFR_WDATA[7] && !P_DONE && !P_CAL_DONE |=> !s_r.p_ready)
      else $error("primary flag survived a zero write");

   // Calibration start clears both result flags
   cal_start_clr_a: assert property (mode_cal && !P_DONE && !P_CAL_DONE && !A_DONE && !A_CAL_DONE
      |=> !s_r.p_ready && !s_r.a_ready)
      else $error("result flags survived calibration start");

   // Calibration completion raises both flags
   cal_set_a: assert property (cal_seen |-> cal_flags_up)
      else $error("calibration completion not flagged");

   // Calibration flag only leaves on a mode write
   cal_keep_a: assert property (s_r.cal && !MODE_WR |=> s_r.cal)
      else $error("calibration flag dropped without mode write");

   // Failed primary calibration raises the fault flag
   cal_fail_a: assert property (P_CAL_DONE && P_CAL_FAIL && p_open |=> s_r.p_fault)
      else $error("failed calibration not flagged");

   // Failed auxiliary calibration raises its fault flag
   aux_fail_a: assert property (A_CAL_DONE && A_CAL_FAIL && a_open && !A_TEMP_SEL |=> s_r.a_fault)
      else $error("failed auxiliary calibration not flagged");

   // Primary fault flag only leaves on a mode write
   err_keep_a: assert property (s_r.p_fault && !MODE_WR |=> s_r.p_fault)
      else $error("primary fault dropped without mode write");

   // Mode write clears the auxiliary fault flag
   a_fault_clr_a: assert property (MODE_WR && !A_DONE && !A_CAL_DONE |=> !s_r.a_fault)
      else $error("auxiliary fault survived mode write");

   // All ones result raises the primary fault flag
   sat_ones_a: assert property (P_DONE && p_open && (&P_RESULT) |=> s_r.p_fault)
      else $error("fault flag missing on full scale result");

   // Auxiliary result clamps to ones without a reference
   aux_clamp_a: assert property (s_r.noref && A_DONE && a_open |=> &s_r.a_data)
      else $error("auxiliary result not clamped");

   // Bad pair A while running raises the flag
   noref_run_a: assert property (ref_lost_run |-> noref_up)
      else $error("missing reference not flagged while running");

   // Good pair A keeps the flag down whatever is selected
   ref_good_a: assert property (!s_r.ref_bad |=> !s_r.noref)
      else $error("missing reference flagged with pair A good");

   // Select register stores the writable bits
   sel_write_a: assert property (sel_wr |=> s_r.sel == ($past(SFR_WDATA) & `ADCSC_SEL_WMASK))
      else $error("select register write lost");

   // Single ended codes pick the matching input against common
   single_end_a: assert property (sel_wr && SFR_WDATA[3:0] < 4'hA
      |=> s_r.neg_in == 4'h0 && s_r.pos_in == $past(SFR_WDATA[3:0]) + 4'h1)
      else $error("single ended decode wrong");

   // Top code shorts common to itself
   common_in_a: assert property (sel_wr && SFR_WDATA[3:0] == 4'hF |=> s_r.pos_in == 4'h0 && s_r.neg_in == 4'h0)
      else $error("common short decode wrong");

   // Select reads return the stored byte
   sel_read_a: assert property (SFR_RD && SFR_ADDR == `ADCSC_SELECT_ADDR |=> SFR_RDATA == $past(s_r.sel))
      else $error("select read data wrong");

   // Unimplemented status bits read zero
   status_low_a: assert property (SFR_RD && SFR_ADDR == `ADCSC_STATUS_ADDR |=> SFR_RDATA[1:0] == 2'b00)
      else $error("unimplemented status bit reads as one");

endmodule // adcsc_top
`default_nettype wire

//--- core/adcsc_defs.svh
// Constants for the converter status and channel select block
//
// Contract
// - Primary result flag, status bit 7, sets on primary conversion or calibration completion.
// - Primary result flag clears on software zero write or calibration mode write.
// - While primary result flag set, primary results never reach data or calibration registers; the code still lets them through in the cycle a clear lands.
// - Status bit 6 is the auxiliary result flag, same rules, auxiliary variant only.
// - Status bit 5 sets on calibration completion, clears only on mode write.
// - Auxiliary calibration with temperature sensor selected never completes nor sets bit 5.
// - Status bit 4 flags bad reference pair A, only while a converter is active.
// - While missing reference flag is set, every stored result is forced to all ones.
// - Only reference pair A is watched; pair B never raises the missing reference flag.
// - Status bit 3 sets when the stored primary result is all zeros or all ones.
// - Primary fault flag sets when a calibration failed to update its coefficients.
// - Primary fault flag clears on any mode write starting conversion or calibration.
// - Status bit 2 is the auxiliary fault flag with primary fault behaviour.
// - Status bits 1 and 0 and select bit 4 ignore writes.
// - Select bits 7:6 pick reference: internal, pair A, pair B, reserved.
// - Select bits 3:0 pick primary input: single ended, differential pairs, common shorted.
`ifndef ADCSC_DEFS_SVH
`define ADCSC_DEFS_SVH

// Register addresses in the special function space
`define ADCSC_STATUS_ADDR 8'hD8
`define ADCSC_SELECT_ADDR 8'hE6
`define ADCSC_STATUS_RST 8'h00
`define ADCSC_SELECT_RST 8'h00

// Status bit positions
`define ADCSC_B_P_READY 3'd7
`define ADCSC_B_A_READY 3'd6
`define ADCSC_B_CAL 3'd5
`define ADCSC_B_NOREF 3'd4
`define ADCSC_B_P_FAULT 3'd3
`define ADCSC_B_A_FAULT 3'd2

// Select field layout and fixed codes
`define ADCSC_SEL_WMASK 8'hEF
`define ADCSC_CH_DIFF0 4'hA
`define ADCSC_CH_COMMON 4'hF
`define ADCSC_IN_COMMON 4'h0

// Lowest mode code that starts a calibration
`define ADCSC_MODE_CAL_MIN 3'h4

// Result width
`define ADCSC_DW 24

`endif

//--- core/adcsc_pkg.sv
// Types for the converter status and channel select block
package adcsc_pkg;

   // Reference source codes
   typedef enum logic [1:0] {
      ADCSC_REF_INT = 2'b00,
      ADCSC_REF_A = 2'b01,
      ADCSC_REF_B = 2'b10,
      ADCSC_REF_RSV = 2'b11
   } adcsc_ref_e;

   // Whole state of the block
   typedef struct packed {
      logic p_ready;
      logic a_ready;
      logic cal;
      logic noref;
      logic p_fault;
      logic a_fault;
      logic [7:0] sel;
      logic [3:0] pos_in;
      logic [3:0] neg_in;
      logic [2:0] ref_sync;
      logic ref_bad;
      logic [23:0] p_data;
      logic [23:0] a_data;
      logic [7:0] rdata;
      logic rvalid;
   } adcsc_state_s;

endpackage

//--- verif/adcsc_conv_model.sv
// Behavioural model of the primary and auxiliary converter datapaths
`timescale 1ns/1ps
`default_nettype none
module adcsc_conv_model (
   // Clock
   input wire logic MCLK,
   // Primary datapath
   output logic P_ACTIVE,
   output logic P_DONE,
   output logic [23:0] P_RESULT,
   output logic P_CAL_DONE,
   output logic P_CAL_FAIL,
   // Auxiliary datapath
   output logic A_ACTIVE,
   output logic A_DONE,
   output logic [23:0] A_RESULT,
   output logic A_CAL_DONE,
   output logic A_CAL_FAIL,
   output logic A_TEMP_SEL
);
   // Idle and stopped until the bench says otherwise
   initial {P_ACTIVE, P_DONE, P_RESULT, P_CAL_DONE, P_CAL_FAIL, A_ACTIVE, A_DONE, A_RESULT,
      A_CAL_DONE, A_CAL_FAIL, A_TEMP_SEL} = '0;
   // Running levels and the temperature sensor input
   task automatic levels(input bit p, input bit a, input bit t);
      @(posedge MCLK);
      {P_ACTIVE, A_ACTIVE, A_TEMP_SEL} <= {p, a, t};
   endtask
   // One done pulse; results turn to junk afterwards so a late sample is caught
   task automatic run(input bit aux, input bit cal, input bit fail, input logic [23:0] r);
      @(posedge MCLK);
      if (aux) {A_DONE, A_CAL_DONE, A_CAL_FAIL, A_RESULT} <= {!cal, cal, fail, r};
      else {P_DONE, P_CAL_DONE, P_CAL_FAIL, P_RESULT} <= {!cal, cal, fail, r};
      @(posedge MCLK);
      {A_DONE, A_CAL_DONE, P_DONE, P_CAL_DONE} <= 4'h0;
      {P_RESULT, A_RESULT} <= {~r, r ^ 24'h5A_5A5A};
   endtask
endmodule // adcsc_conv_model
`default_nettype wire

//--- verif/adc_status_channel_select_tb_top.sv
// Self-checking bench for the converter status and select block
`timescale 1ns/1ps
`default_nettype none
module adc_status_channel_select_tb_top;
   // Pins named as the ports they meet, plus the reference model state
   logic MCLK = 0, RESETN = 0, SFR_WR = 0, SFR_RD = 0, SFR_BIT_WR = 0, SFR_BIT_VAL = 0, MODE_WR = 0;
   logic REF_A_BAD = 0, SFR_RVALID, P_WR_EN, A_WR_EN, NOREF, P_ACTIVE, P_DONE, P_CAL_DONE, P_CAL_FAIL;
   logic A_ACTIVE, A_DONE, A_CAL_DONE, A_CAL_FAIL, A_TEMP_SEL;
   logic [7:0] SFR_ADDR = '0, SFR_WDATA = '0, SFR_BIT_ADDR = '0, SFR_RDATA, q, d;
   logic [2:0] MODE_FIELD = '0;
   logic [23:0] P_RESULT, A_RESULT, P_DATA, A_DATA, mp = '0, ma = '0, r;
   logic [1:0] REF_SEL;
   logic [3:0] CH_SEL, POS_IN, NEG_IN;
   int failures = 0, n_tests = 0, ms = 0, i, ch;
   // Core clock
   always #5 MCLK = ~MCLK;
   // Block and its converter partner
   adcsc_top dut_u (.MCLK, .RESETN, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RD, .SFR_BIT_WR,
      .SFR_BIT_ADDR, .SFR_BIT_VAL, .SFR_RDATA, .SFR_RVALID, .MODE_WR, .MODE_FIELD, .P_ACTIVE,
      .P_DONE, .P_RESULT, .P_CAL_DONE, .P_CAL_FAIL, .P_WR_EN, .P_DATA, .A_ACTIVE, .A_DONE,
      .A_RESULT, .A_CAL_DONE, .A_CAL_FAIL, .A_TEMP_SEL, .A_WR_EN, .A_DATA, .REF_A_BAD,
      .REF_SEL, .CH_SEL, .POS_IN, .NEG_IN, .NOREF);
   adcsc_conv_model cm_u (.MCLK, .P_ACTIVE, .P_DONE, .P_RESULT, .P_CAL_DONE, .P_CAL_FAIL,
      .A_ACTIVE, .A_DONE, .A_RESULT, .A_CAL_DONE, .A_CAL_FAIL, .A_TEMP_SEL);
   // Compare and count
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %0h got %0h", n, e, g);
      end
   endtask
   // Byte access; read data is taken in the valid cycle
   task automatic acc(bit w, logic [7:0] a, logic [7:0] wd);
      @(posedge MCLK);
      {SFR_ADDR, SFR_WDATA, SFR_WR, SFR_RD} <= {a, wd, w, !w};
      @(posedge MCLK);
      {SFR_WR, SFR_RD} <= 2'b00;
      #1;
      q = SFR_RDATA;
      if (!w) chk("rvalid", 1, SFR_RVALID);
   endtask
   // Single status bit write
   task automatic bitw(int n, bit v);
      @(posedge MCLK);
      {SFR_BIT_ADDR, SFR_BIT_VAL, SFR_BIT_WR} <= {8'hD8 | 8'(n), v, 1'b1};
      @(posedge MCLK);
      SFR_BIT_WR <= 0;
      if (!v && n > 5) ms[n] = 0;
   endtask
   // Mode field write; calibration codes also drop both result flags
   task automatic mode(logic [2:0] f);
      @(posedge MCLK);
      {MODE_WR, MODE_FIELD} <= {1'b1, f};
      @(posedge MCLK);
      MODE_WR <= 0;
      ms &= f > 3 ? 8'h10 : 8'hD3;
   endtask
   // Status and held outputs against the model
   task automatic stat();
      acc(0, 8'hD8, 0);
      chk("status", ms, q);
      chk("pdata", mp, P_DATA);
      chk("adata", ma, A_DATA);
      chk("p_wr_en", !ms[7], P_WR_EN);
      chk("a_wr_en", !ms[6], A_WR_EN);
      chk("noref", ms[4], NOREF);
   endtask
   // One datapath event, mirrored in the model; a blocked one leaves it alone
   task automatic conv(bit aux, bit cal, bit fail, logic [23:0] v);
      int b = 7 - aux;
      cm_u.run(aux, cal, fail, v);
      if (ms[4]) v = 24'hFF_FFFF;
      if (ms[b] || (aux && cal && A_TEMP_SEL)) return;
      ms[b] = 1;
      ms[5] |= cal;
      ms[b - 4] |= cal ? fail : (v == 0 || v == 24'hFF_FFFF);
      if (!cal && aux) ma = v;
      if (!cal && !aux) mp = v;
   endtask
   // Verdict and end of run
   task automatic print_verdict();
      if (failures == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge MCLK);
      failures++;
      print_verdict();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h853f_e809));
      repeat (8) @(posedge MCLK);
      RESETN <= 1;
      stat();
      acc(0, 8'hE6, 0);
      chk("sel_rst", 0, q);
      chk("pos_rst", 1, POS_IN);
      // Every reference and channel code, noise in bits 5 and 4; full pinout so all are legal
      for (i = 0; i < 64; i++) begin
         d = {i[5:4], 2'($urandom), i[3:0]};
         acc(1, 8'hE6, d);
         acc(0, 8'hE6, 0);
         ch = i % 16;
         chk("select", d & 8'hEF, q);
         chk("ref_sel", i / 16, REF_SEL);
         chk("ch_sel", ch, CH_SEL);
         chk("pos_in", ch < 10 ? ch + 1 : ch < 15 ? 2 * ch - 19 : 0, POS_IN);
         chk("neg_in", (ch < 10 || ch > 14) ? 0 : 2 * ch - 18, NEG_IN);
      end
      acc(1, 8'h55, 8'hFF);
      acc(0, 8'h55, 0);
      chk("unmapped", 0, q);
      // Results with saturated values, a blocked second result, both ways of clearing
      cm_u.levels(1, 1, 0);
      for (i = 0; i < 24; i++) begin
         r = i % 3 == 0 ? 24'h00_0000 : i % 3 == 1 ? 24'hFF_FFFF : 24'($urandom);
         conv(i[0], 0, 0, r);
         conv(i[0], 0, 0, ~r);
         bitw(i % 6, 1);
         stat();
         if (i[1]) bitw(7 - i[0], 0);
         else acc(1, 8'hD8, 8'h3F);
         ms &= 8'h3F;
         stat();
         mode(3'h1);
      end
      // Calibration outcome, then every mode code
      conv(0, 0, 0, 24'h12_3456);
      for (i = 0; i < 8; i++) begin
         bitw(7, 0);
         conv(0, 1, i[0], 0);
         stat();
         mode(i[2:0]);
         stat();
      end
      cm_u.levels(1, 1, 1);
      conv(1, 1, 0, 0);
      stat();
      cm_u.levels(1, 1, 0);
      conv(1, 1, 1, 0);
      stat();
      // Reference lost while running, restored, then lost while idle
      @(posedge MCLK) REF_A_BAD <= 1;
      repeat (5) @(posedge MCLK);
      ms |= 8'h10;
      stat();
      conv(0, 0, 0, 24'h00_1234);
      stat();
      @(posedge MCLK) REF_A_BAD <= 0;
      repeat (5) @(posedge MCLK);
      ms &= 8'hEF;
      stat();
      cm_u.levels(0, 0, 0);
      @(posedge MCLK) REF_A_BAD <= 1;
      repeat (5) @(posedge MCLK);
      stat();
      print_verdict();
   end
endmodule // adc_status_channel_select_tb_top
`default_nettype wire
